// >>> hdl/pes_top.v
`include "pes_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Bit 31 marks overwritten, latest kept
// - Hardware never sets overwrite with zero cause
// - Bits 27:24 hold cause codes 0..7 from hardware; software may write any value
// - Bits 23:16 group, else zero
// - Bits 15:0 partition when captured
// - Bits 15:0 monitor index when captured
// - Bits 15:0 zero when nothing captured
// - Register errors record syndrome, raise interrupt
// - Errors never block request service
// - Partition selector out of range: cause 1
// - Request partition out of range: cause 2
// - Cause-2 request uses default partition
// - Monitor config id out of range: cause 3
// - Request group out of range: cause 4
// - Cause-4 request uses default group
// - Monitor selector out of range: cause 5
// - Internal partition out of range: cause 6
// - Unexpected internal flag: cause 7
// - Bank chosen by access or request security
// - Syndrome at 0x00f8, banked, read-write
// - Interrupt only when bank enable set
// - Each error overwrites, config beating a same-cycle request in one bank; flag if cause held
// - Errored config read returns undefined data
module pes_top #(
	parameter PART_W = 16,
	parameter GROUP_W = 8,
	parameter MON_W = 16,
	parameter [15:0] PART_MAX_S = 16'h00ff,
	parameter [15:0] PART_MAX_NS = 16'h00ff,
	parameter [15:0] INT_PART_MAX_S = 16'h000f,
	parameter [15:0] INT_PART_MAX_NS = 16'h000f,
	parameter [7:0] GROUP_MAX_S = 8'h01,
	parameter [7:0] GROUP_MAX_NS = 8'h01,
	parameter [15:0] MON_MAX = 16'h0007,
	parameter [15:0] DEFAULT_PART = 16'h0000,
	parameter [7:0] DEFAULT_GROUP = 8'h00
) (
	input wire sys_clk,
	input wire sys_rst,
	// Register port
	input wire reg_valid,
	input wire reg_write,
	input wire access_security_bit,
	input wire [15:0] reg_offset,
	input wire [31:0] reg_wdata,
	output reg reg_ready,
	output reg [31:0] reg_rdata,
	// Configuration access check, supplied by the controller
	input wire cfg_check,
	input wire cfg_security_bit,
	input wire cfg_part_store,
	input wire cfg_mon_cfg_write,
	input wire cfg_mon_store,
	input wire cfg_map_write,
	input wire cfg_expects_internal,
	input wire cfg_internal_flag,
	input wire [PART_W-1:0] cfg_partition,
	input wire [GROUP_W-1:0] cfg_group,
	input wire [MON_W-1:0] monitor_selector,
	input wire [PART_W-1:0] internal_partition,
	// Incoming memory request
	input wire req_valid,
	input wire request_security_bit,
	input wire [PART_W-1:0] requested_partition,
	input wire [GROUP_W-1:0] req_group,
	output reg out_valid,
	output reg out_security_bit,
	output reg [PART_W-1:0] out_partition,
	output reg [GROUP_W-1:0] out_group,
	output reg out_group_mismatch,
	output reg error_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Range checks

	wire [15:0] part_ext;
	wire [15:0] cpart_ext;
	wire [15:0] ipart_ext;
	wire [15:0] mon_ext;
	wire [7:0] grp_ext;
	wire [7:0] cgrp_ext;
	wire [15:0] req_pmax;
	wire [7:0] req_gmax;
	wire [15:0] cfg_pmax;
	wire [15:0] cfg_imax;
	wire [7:0] cfg_gmax;
	assign part_ext = requested_partition;
	assign cpart_ext = cfg_partition;
	assign ipart_ext = internal_partition;
	assign mon_ext = monitor_selector;
	assign grp_ext = req_group;
	assign cgrp_ext = cfg_group;
	assign req_pmax = request_security_bit ? PART_MAX_NS : PART_MAX_S;
	assign req_gmax = request_security_bit ? GROUP_MAX_NS : GROUP_MAX_S;
	assign cfg_pmax = cfg_security_bit ? PART_MAX_NS : PART_MAX_S;
	assign cfg_imax = cfg_security_bit ? INT_PART_MAX_NS : INT_PART_MAX_S;
	assign cfg_gmax = cfg_security_bit ? GROUP_MAX_NS : GROUP_MAX_S;

	wire req_part_bad;
	wire req_grp_bad;
	assign req_part_bad = req_valid && (part_ext > req_pmax);
	assign req_grp_bad = req_valid && (grp_ext > req_gmax);

	// Configuration errors, priority: selector, internal flag, map, monitor
	reg cfg_err;
	reg [3:0] cfg_cause;
	reg [7:0] cfg_egrp;
	reg [15:0] cfg_eidx;
	always @* begin
		cfg_err = 1'b0;
		cfg_cause = `PES_CAUSE_NONE;
		cfg_egrp = 8'h00;
		cfg_eidx = 16'h0000;
		if (cfg_check) begin
			if (cfg_part_store && cpart_ext > cfg_pmax) begin
				cfg_err = 1'b1;
				cfg_cause = `PES_CAUSE_PSEL;
				cfg_eidx = cpart_ext;
			end else if (cfg_part_store && cfg_internal_flag && !cfg_expects_internal) begin
				cfg_err = 1'b1;
				cfg_cause = `PES_CAUSE_INTERNAL;
				cfg_eidx = cpart_ext;
			end else if (cfg_map_write && ipart_ext > cfg_imax) begin
				cfg_err = 1'b1;
				cfg_cause = `PES_CAUSE_INT_PART;
				cfg_eidx = ipart_ext;
			end else if (cfg_mon_store && mon_ext > MON_MAX) begin
				cfg_err = 1'b1;
				cfg_cause = `PES_CAUSE_MONITOR_SELECTOR;
				cfg_eidx = mon_ext;
			end else if (cfg_mon_cfg_write && (cpart_ext > cfg_pmax || cgrp_ext > cfg_gmax)) begin
				cfg_err = 1'b1;
				cfg_cause = `PES_CAUSE_MON_ID;
				cfg_egrp = cgrp_ext;
				cfg_eidx = cpart_ext;
			end
		end
	end

	wire req_err;
	wire [3:0] req_cause;
	assign req_err = req_part_bad || req_grp_bad;
	// Partition fault outranks group fault; both capture the same fields
	assign req_cause = req_part_bad ? `PES_CAUSE_REQ_PART : `PES_CAUSE_REQ_GRP;

	////////////////////////////////////////////////////////////////////////////
	// Register access decode

	wire rd_req;
	wire wr_req;
	wire esr_hit;
	wire ecr_hit;
	assign rd_req = reg_valid && !reg_write;
	assign wr_req = reg_valid && reg_write;
	assign esr_hit = reg_offset == `PES_ESR_OFFSET;
	assign ecr_hit = reg_offset == `PES_ECR_OFFSET;

	// Software reaches only the bank of its own security state
	wire esr_we_s;
	wire esr_we_ns;
	wire ecr_we_s;
	wire ecr_we_ns;
	assign esr_we_s = wr_req && esr_hit && !access_security_bit;
	assign esr_we_ns = wr_req && esr_hit && access_security_bit;
	assign ecr_we_s = wr_req && ecr_hit && !access_security_bit;
	assign ecr_we_ns = wr_req && ecr_hit && access_security_bit;

	////////////////////////////////////////////////////////////////////////////
	// Error routing: config errors by access bank, request errors by request bank

	wire cfg_hit_s;
	wire cfg_hit_ns;
	wire req_hit_s;
	wire req_hit_ns;
	assign cfg_hit_s = cfg_err && !cfg_security_bit;
	assign cfg_hit_ns = cfg_err && cfg_security_bit;
	assign req_hit_s = req_err && !request_security_bit;
	assign req_hit_ns = req_err && request_security_bit;

	// Config error wins when both strike one bank in a cycle; the
	// request error is then lost, costing only its syndrome record
	wire err_s;
	wire err_ns;
	wire [3:0] cause_s;
	wire [3:0] cause_ns;
	wire [7:0] group_s;
	wire [7:0] group_ns;
	wire [15:0] index_s;
	wire [15:0] index_ns;
	assign err_s = cfg_hit_s || req_hit_s;
	assign err_ns = cfg_hit_ns || req_hit_ns;
	assign cause_s = cfg_hit_s ? cfg_cause : req_cause;
	assign cause_ns = cfg_hit_ns ? cfg_cause : req_cause;
	assign group_s = cfg_hit_s ? cfg_egrp : grp_ext;
	assign group_ns = cfg_hit_ns ? cfg_egrp : grp_ext;
	assign index_s = cfg_hit_s ? cfg_eidx : part_ext;
	assign index_ns = cfg_hit_ns ? cfg_eidx : part_ext;

	////////////////////////////////////////////////////////////////////////////
	// Banks: secure and non-secure syndrome plus enable

	wire [31:0] esr_s;
	wire [31:0] esr_ns;
	wire ien_s;
	wire ien_ns;

	pes_bank u_bank_s (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.sw_esr_we(esr_we_s),
		.sw_ecr_we(ecr_we_s),
		.sw_wdata(reg_wdata),
		.err_valid(err_s),
		.err_cause(cause_s),
		.err_group(group_s),
		.err_index(index_s),
		.esr(esr_s),
		.irq_enable(ien_s)
	);

	pes_bank u_bank_ns (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.sw_esr_we(esr_we_ns),
		.sw_ecr_we(ecr_we_ns),
		.sw_wdata(reg_wdata),
		.err_valid(err_ns),
		.err_cause(cause_ns),
		.err_group(group_ns),
		.err_index(index_ns),
		.esr(esr_ns),
		.irq_enable(ien_ns)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register read port

	wire [31:0] esr_sel;
	wire ien_sel;
	assign esr_sel = access_security_bit ? esr_ns : esr_s;
	assign ien_sel = access_security_bit ? ien_ns : ien_s;

	// Read data holds between reads, so a late sample still sees it
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_ready <= 1'b0;
			reg_rdata <= 32'h00000000;
		end else begin
			reg_ready <= reg_valid;
			// Errored config reads land here too; data is not guaranteed
			if (rd_req) begin
				if (esr_hit) begin
					reg_rdata <= esr_sel;
				end else if (ecr_hit) begin
					reg_rdata <= {31'h00000000, ien_sel};
				end else begin
					reg_rdata <= 32'h00000000;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request pass-through

	// Requests always pass; any bad id swaps both ids for the defaults
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_security_bit <= 1'b0;
			out_partition <= {PART_W{1'b0}};
			out_group <= {GROUP_W{1'b0}};
			out_group_mismatch <= 1'b0;
		end else begin
			out_valid <= req_valid;
			out_security_bit <= request_security_bit;
			out_partition <= req_err ? DEFAULT_PART[PART_W-1:0] : requested_partition;
			out_group <= req_err ? DEFAULT_GROUP[GROUP_W-1:0] : req_group;
			out_group_mismatch <= req_grp_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt

	wire held_s;
	wire held_ns;
	assign held_s = esr_s[`PES_CAUSE_HI:`PES_CAUSE_LO] != `PES_CAUSE_NONE;
	assign held_ns = esr_ns[`PES_CAUSE_HI:`PES_CAUSE_LO] != `PES_CAUSE_NONE;

	// Level, not pulse: clearing the cause or the enable drops it
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			error_irq <= 1'b0;
		end else begin
			error_irq <= (ien_s && held_s) || (ien_ns && held_ns);
		end
	end

endmodule

// >>> include/pes_map.vh
`ifndef PES_MAP_VH
`define PES_MAP_VH
`define PES_ECR_OFFSET 16'h00f0
`define PES_ESR_OFFSET 16'h00f8
`define PES_OVR_BIT 31
`define PES_CAUSE_HI 27
`define PES_CAUSE_LO 24
`define PES_GROUP_HI 23
`define PES_GROUP_LO 16
`define PES_INDEX_HI 15
`define PES_INDEX_LO 0
`define PES_IRQEN_BIT 0
`define PES_ESR_RESET 32'h00000000
`define PES_ECR_RESET 32'h00000000
`define PES_ESR_WMASK 32'h8fffffff
`define PES_CAUSE_NONE 4'h0
`define PES_CAUSE_PSEL 4'h1
`define PES_CAUSE_REQ_PART 4'h2
`define PES_CAUSE_MON_ID 4'h3
`define PES_CAUSE_REQ_GRP 4'h4
`define PES_CAUSE_MONITOR_SELECTOR 4'h5
`define PES_CAUSE_INT_PART 4'h6
`define PES_CAUSE_INTERNAL 4'h7
`endif

// >>> hdl/pes_bank.v
`include "pes_map.vh"

// One security bank: syndrome plus interrupt enable
module pes_bank (
	input wire sys_clk,
	input wire sys_rst,
	input wire sw_esr_we,
	input wire sw_ecr_we,
	input wire [31:0] sw_wdata,
	input wire err_valid,
	input wire [3:0] err_cause,
	input wire [7:0] err_group,
	input wire [15:0] err_index,
	output reg [31:0] esr,
	output reg irq_enable
);

	wire cause_held;
	assign cause_held = esr[`PES_CAUSE_HI:`PES_CAUSE_LO] != `PES_CAUSE_NONE;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			esr <= `PES_ESR_RESET;
			irq_enable <= 1'b0;
		end else begin
			// Error wins over a software write in the same cycle
			if (err_valid && err_cause != `PES_CAUSE_NONE) begin
				esr <= {cause_held, 3'b000, err_cause, err_group, err_index};
			end else if (sw_esr_we) begin
				esr <= sw_wdata & `PES_ESR_WMASK;
			end
			if (sw_ecr_we) begin
				irq_enable <= sw_wdata[`PES_IRQEN_BIT];
			end
		end
	end

endmodule

// >>> verification/pes_props.sv
module pes_props #(
	parameter [15:0] PART_MAX_S = 16'h00ff,
	parameter [7:0] GROUP_MAX_S = 8'h01,
	parameter [15:0] DEFAULT_PART = 16'h0000,
	parameter [7:0] DEFAULT_GROUP = 8'h00
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire reg_valid,
	input wire reg_write,
	input wire access_security_bit,
	input wire [15:0] reg_offset,
	input wire [31:0] reg_wdata,
	input wire reg_ready,
	input wire [31:0] reg_rdata,
	input wire req_valid,
	input wire request_security_bit,
	input wire [15:0] requested_partition,
	input wire [7:0] req_group,
	input wire out_valid,
	input wire [15:0] out_partition,
	input wire [7:0] out_group,
	input wire error_irq
);
timeunit 1ns;
timeprecision 1ns;
wire sec_req = req_valid && !request_security_bit;
reg sw_odd;
reg en_s;
reg en_ns;
// Software may plant any code; hardware-only checks stop after that
always @(posedge sys_clk or posedge sys_rst) begin
	if (sys_rst) begin
		sw_odd <= 1'b0;
		en_s <= 1'b0;
		en_ns <= 1'b0;
	end else if (reg_valid && reg_write) begin
		if (reg_offset == 16'h00f8 && (reg_wdata[27:24] > 4'h7 ||
			(reg_wdata[31] && reg_wdata[27:24] == 4'h0))) begin
			sw_odd <= 1'b1;
		end
		if (reg_offset == 16'h00f0 && !access_security_bit) begin
			en_s <= reg_wdata[0];
		end
		if (reg_offset == 16'h00f0 && access_security_bit) begin
			en_ns <= reg_wdata[0];
		end
	end
end
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
property p_ready; reg_valid |=> reg_ready; endproperty
a_ready: assert property (p_ready) else $error("ready missing");
property p_no_ready; !reg_valid |=> !reg_ready; endproperty
a_no_ready: assert property (p_no_ready) else $error("stray ready");
property p_out; req_valid |=> out_valid; endproperty
a_out: assert property (p_out) else $error("request dropped");
property p_pass; sec_req && requested_partition <= PART_MAX_S && req_group <= GROUP_MAX_S
	|=> out_partition == $past(requested_partition) && out_group == $past(req_group); endproperty
a_pass: assert property (p_pass) else $error("good request altered");
property p_def_part; sec_req && requested_partition > PART_MAX_S
	|=> out_partition == DEFAULT_PART; endproperty
a_def_part: assert property (p_def_part) else $error("bad partition kept");
property p_def_grp; sec_req && req_group > GROUP_MAX_S |=> out_group == DEFAULT_GROUP; endproperty
a_def_grp: assert property (p_def_grp) else $error("bad group kept");
property p_rsv; reg_valid && !reg_write && reg_offset == 16'h00f8
	|=> reg_rdata[30:28] == 3'h0; endproperty
a_rsv: assert property (p_rsv) else $error("reserved syndrome bits");
property p_code; reg_valid && !reg_write && reg_offset == 16'h00f8 && !sw_odd
	|=> reg_rdata[27:24] <= 4'h7; endproperty
a_code: assert property (p_code) else $error("reserved cause recorded");
property p_ovr; reg_valid && !reg_write && reg_offset == 16'h00f8 && !sw_odd
	|=> !(reg_rdata[31] && reg_rdata[27:24] == 4'h0); endproperty
a_ovr: assert property (p_ovr) else $error("overwrite flag with zero cause");
property p_irq_off; !en_s && !en_ns |=> !error_irq; endproperty
a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
property p_hold; !(reg_valid && !reg_write) |=> $stable(reg_rdata); endproperty
a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind pes_top pes_props #(.PART_MAX_S(PART_MAX_S), .GROUP_MAX_S(GROUP_MAX_S),
	.DEFAULT_PART(DEFAULT_PART), .DEFAULT_GROUP(DEFAULT_GROUP)) u_props (.sys_clk, .sys_rst,
	.reg_valid, .reg_write, .access_security_bit, .reg_offset, .reg_wdata, .reg_ready,
	.reg_rdata, .req_valid, .request_security_bit, .requested_partition, .req_group,
	.out_valid, .out_partition, .out_group, .error_irq);

// >>> verification/pes_requester.sv
// Memory requester on the far side
module pes_requester (
	input wire sys_clk,
	output reg req_valid = 1'b0,
	output reg request_security_bit = 1'b0,
	output reg [15:0] requested_partition = 16'h0000,
	output reg [7:0] req_group = 8'h00
);
timeunit 1ns;
timeprecision 1ns;
task send(input s, input [15:0] p, input [7:0] g);
	@(posedge sys_clk);
	req_valid <= 1'b1;
	request_security_bit <= s;
	requested_partition <= p;
	req_group <= g;
	@(posedge sys_clk);
	req_valid <= 1'b0;
	// Released lines show junk, not the last value
	requested_partition <= ~p;
	req_group <= ~g;
	#1;
endtask
endmodule

// >>> verification/testbench.sv
module testbench;
timeunit 1ns;
timeprecision 1ns;
reg sys_clk = 1'b0;
reg sys_rst = 1'b1;
reg reg_valid = 1'b0, reg_write = 1'b0, access_security_bit = 1'b0, cfg_check = 1'b0, cs = 1'b0;
reg [15:0] reg_offset = 16'h0000, v = 16'h0000;
reg [31:0] reg_wdata = 32'h00000000, d;
reg [5:0] k = 6'h00;
wire reg_ready, req_valid, request_security_bit, out_valid, error_irq;
wire out_security_bit, out_group_mismatch;
wire [31:0] reg_rdata;
wire [15:0] requested_partition, out_partition;
wire [7:0] req_group, out_group;
int fail_count = 0;
int checked = 0;
pes_requester req_m (.sys_clk, .req_valid, .request_security_bit, .requested_partition,
	.req_group);
pes_top dut (.sys_clk, .sys_rst, .reg_valid, .reg_write, .access_security_bit, .reg_offset,
	.reg_wdata, .reg_ready, .reg_rdata, .cfg_check, .cfg_security_bit(cs), .cfg_part_store(k[0]),
	.cfg_mon_cfg_write(k[1]), .cfg_mon_store(k[2]), .cfg_map_write(k[3]),
	.cfg_expects_internal(k[5]), .cfg_internal_flag(k[4]), .cfg_partition(v),
	.cfg_group(v[7:0]), .monitor_selector(v), .internal_partition(v), .req_valid,
	.request_security_bit, .requested_partition, .req_group, .out_valid, .out_security_bit,
	.out_partition, .out_group, .out_group_mismatch, .error_irq);
////////////////////////////////////////
initial forever #5 sys_clk = ~sys_clk;
task chk(input [31:0] g, input [31:0] e);
	checked++;
	if (g !== e) begin
		fail_count++;
		$display("unexpected at %0t got %h exp %h", $time, g, e);
	end
endtask
task acc(input w, input s, input [15:0] o, input [31:0] wd);
	@(posedge sys_clk);
	reg_valid <= 1'b1;
	reg_write <= w;
	access_security_bit <= s;
	reg_offset <= o;
	reg_wdata <= wd;
	@(posedge sys_clk);
	reg_valid <= 1'b0;
	#1;
	d = reg_rdata;
	chk(reg_ready, 1);
endtask
task cfg(input [5:0] kk, input s, input [15:0] vv);
	@(posedge sys_clk);
	cfg_check <= 1'b1;
	k <= kk;
	cs <= s;
	v <= vv;
	@(posedge sys_clk);
	cfg_check <= 1'b0;
	k <= 6'h00;
	v <= ~vv;
endtask
task rd(input s, input [31:0] e);
	acc(0, s, 16'h00f8, 0);
	chk(d, e);
endtask
// Clear first so each case reads only its own fresh error, or none
task t_one(input [5:0] kk, input [15:0] vv, input [31:0] e);
	acc(1, 0, 16'h00f8, 0);
	cfg(kk, 0, vv);
	rd(0, e);
	chk(error_irq, 0);
endtask
task print_verdict;
	$display("checks %0d errors %0d", checked, fail_count);
	if (fail_count == 0 && checked > 0) $display("STATUS OK");
	else $display("STATUS NOT OK");
	$finish;
endtask
////////////////////////////////////////
initial begin
	#100000;
	fail_count++;
	print_verdict;
end
initial begin
	repeat (8) @(posedge sys_clk);
	sys_rst <= 1'b0;
	rd(0, 0);
	rd(1, 0);
	acc(0, 1, 16'h00f0, 0);
	chk(d, 0);
	t_one(6'h01, 16'h0120, 32'h01000120);
	t_one(6'h11, 16'h0010, 32'h07000010);
	t_one(6'h31, 16'h0010, 32'h00000000);
	t_one(6'h08, 16'h0020, 32'h06000020);
	t_one(6'h04, 16'h0020, 32'h05000020);
	t_one(6'h02, 16'h0120, 32'h03200120);
	t_one(6'h02, 16'h0005, 32'h03050005);
	cfg(6'h04, 0, 16'h0009);
	rd(0, 32'h85000009);
	acc(1, 0, 16'h00f8, 0);
	req_m.send(0, 16'h0007, 8'h01);
	chk(out_partition, 7);
	req_m.send(0, 16'h01ff, 8'h01);
	chk(out_partition, 0);
	chk(out_group_mismatch, 0);
	rd(0, 32'h020101ff);
	req_m.send(0, 16'h0005, 8'h02);
	chk(out_group, 0);
	chk(out_group_mismatch, 1);
	rd(0, 32'h84020005);
	req_m.send(1, 16'h01ff, 8'h00);
	chk(out_security_bit, 1);
	chk(out_partition, 0);
	rd(1, 32'h020001ff);
	rd(0, 32'h84020005);
	chk(error_irq, 0);
	acc(1, 1, 16'h00f0, 1);
	repeat (2) @(posedge sys_clk);
	#1 chk(error_irq, 1);
	acc(1, 1, 16'h00f8, 0);
	repeat (2) @(posedge sys_clk);
	#1 chk(error_irq, 0);
	acc(1, 0, 16'h00f8, 32'hffffffff);
	rd(0, 32'h8fffffff);
	acc(0, 0, 16'h0100, 0);
	chk(d, 0);
	print_verdict;
end
endmodule
